// ---- core/tcc_pkg.sv ----
// Shared constants and carrier types for the three-channel timer core.
package tcc_pkg;
    // Channel count and counter width.
    localparam int          NCH      = 3;
    localparam int          CW       = 16;
    localparam int          NTAP     = 5;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE  = 16'h0001;
    // Clock source select codes: taps 1..5, then external lines 0..2.
    localparam logic [2:0]  CS_TAP1  = 3'h0;
    localparam logic [2:0]  CS_XC0   = 3'h5;
    // Burst gate codes.
    localparam logic [1:0]  BU_NONE  = 2'h0;
    localparam logic [1:0]  BU_XC0   = 2'h1;
    // Block mode routing of each external clock line.
    localparam logic [1:0]  XR_PIN   = 2'h0;
    localparam logic [1:0]  XR_ANEXT = 2'h1;
    localparam logic [1:0]  XR_APREV = 2'h2;
    localparam logic [1:0]  XR_OFF   = 2'h3;

    // Channel mode register fields.
    typedef struct packed {
        logic [2:0] clk_sel;
        logic       clk_inv;
        logic [1:0] burst;
        logic       wave;
        logic       b_out;
    } tcc_mode_t;

    // Per-channel command pulses.
    typedef struct packed {
        logic sw_trig;
        logic clk_en;
        logic clk_dis;
        logic ovf_clr;
    } tcc_cmd_t;

    // Per-channel state.
    typedef struct packed {
        logic [15:0] cnt;
        logic        ovf;
        logic        en;
        logic        run;
        logic        pend;
        logic        lvl;
        logic        aout;
    } tcc_chan_t;

    // Whole-block state.
    typedef struct packed {
        logic [2:0]            pin_s1;
        logic [2:0]            pin_s2;
        logic [2:0]            ioa_s1;
        logic [2:0]            ioa_s2;
        tcc_chan_t [2:0]       ch;
    } tcc_state_t;
endpackage

// ---- core/tcc_core.sv ----
// Three-channel 16-bit timer counter core with block-level clock routing.
`timescale 1ns/1ns

module tcc_core
    import tcc_pkg::*;
(
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset,
    input  wire logic [NTAP-1:0]      i_tap,
    input  wire logic [2:0]           i_ext_pin,
    input  wire logic [2:0][1:0]      i_xc_route,
    input  wire tcc_mode_t [NCH-1:0]  i_mode,
    input  wire tcc_cmd_t  [NCH-1:0]  i_cmd,
    input  wire logic                 i_block_sync,
    input  wire logic [NCH-1:0]       i_int_en,
    input  wire logic [NCH-1:0]       i_ioa_in,
    input  wire logic [NCH-1:0]       i_iob_in,
    output logic [NCH-1:0][CW-1:0]    o_count,
    output logic [NCH-1:0]            o_ovf,
    output logic [NCH-1:0]            o_clk_sta,
    output logic [NCH-1:0]            o_int,
    output logic [NCH-1:0]            o_ioa_out,
    output logic [NCH-1:0]            o_ioa_oe,
    output logic [NCH-1:0]            o_iob_out,
    output logic [NCH-1:0]            o_iob_oe
);

    // Registered state and its next value.
    // All state sits in one struct, so reset and update stay in step.
    tcc_state_t      s_q;
    tcc_state_t      s_d;
    // Level seen on each channel's A-line, for chaining.
    logic [NCH-1:0]  alev;
    // Routed external clock lines.
    logic [2:0]      xc;
    // Selected and possibly inverted clock level.
    logic [NCH-1:0]  sel_lvl;
    // Burst gate level.
    logic [NCH-1:0]  gate;
    // Qualified counting edge.
    logic [NCH-1:0]  edge_ok;
    // Trigger pulse per channel.
    logic [NCH-1:0]  trig;
    // Enable after this cycle's commands.
    logic [NCH-1:0]  en_nx;
    // Overflow event this cycle.
    logic [NCH-1:0]  ovf_set;

    // Next-state logic for the whole block.
    // Clock edges are found by comparing the selected level with the
    // level held last cycle, so every counter runs on the core clock.
    // The price is that an outside clock must stay well below it.
    // Keeping one clock also means no counter ever crosses a domain,
    // so the live count can be read at any time without a snapshot.
    // Edges closer than two core cycles apart are simply merged.
    always_comb begin
        s_d = s_q;
        // Two-flop synchronisers; only stage two is looked at.
        // Stage one may go metastable, so nothing else reads it.
        // Pins and A inputs both cross from the outside world here.
        s_d.pin_s1 = i_ext_pin;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.ioa_s1 = i_ioa_in;
        s_d.ioa_s2 = s_q.ioa_s1;
        // A-line level: own output in waveform mode, else the pin.
        for (int n = 0; n < NCH; n++) begin
            if (i_mode[n].wave) begin
                alev[n] = s_q.ch[n].aout;
            end else begin
                alev[n] = s_q.ioa_s2[n];
            end
        end
        // Each external line takes its pin or another channel's A.
        // Chaining lets one channel's A output clock a neighbour.
        // The off code parks the line low so it never makes an edge.
        for (int n = 0; n < 3; n++) begin
            unique case (i_xc_route[n])
                XR_PIN:   xc[n] = s_q.pin_s2[n];
                XR_ANEXT: xc[n] = alev[(n + 1) % NCH];
                XR_APREV: xc[n] = alev[(n + 2) % NCH];
                XR_OFF:   xc[n] = 1'b0;
            endcase
        end
        // Per-channel counting.
        for (int n = 0; n < NCH; n++) begin
            // Clock source: taps below the first line code.
            if (i_mode[n].clk_sel < CS_XC0) begin
                sel_lvl[n] = i_tap[i_mode[n].clk_sel];
            end else begin
                sel_lvl[n] = xc[2'(i_mode[n].clk_sel - CS_XC0)];
            end
            // Inversion moves counting to the opposite edge.
            sel_lvl[n] = sel_lvl[n] ^ i_mode[n].clk_inv;
            // Burst lets edges through only while the line is high.
            // The gate is read in the same cycle as the edge it passes.
            // A gate that falls with the clock edge therefore blocks it.
            if (i_mode[n].burst == BU_NONE) begin
                gate[n] = 1'b1;
            end else begin
                gate[n] = xc[2'(i_mode[n].burst - BU_XC0)];
            end
            // Rising edge of the selected level, gated and running.
            edge_ok[n] = sel_lvl[n] & ~s_q.ch[n].lvl & gate[n]
                       & s_q.ch[n].en & s_q.ch[n].run;
            s_d.ch[n].lvl = sel_lvl[n];
            // Software, block sync: all are triggers.
            trig[n] = i_cmd[n].sw_trig | i_block_sync;
            // Disable wins over enable if both arrive together.
            // That way a stray enable can never undo a stop in progress.
            if (i_cmd[n].clk_dis) begin
                en_nx[n] = 1'b0;
            end else if (i_cmd[n].clk_en) begin
                en_nx[n] = 1'b1;
            end else begin
                en_nx[n] = s_q.ch[n].en;
            end
            s_d.ch[n].en = en_nx[n];
            // A trigger starts the clock only while enabled.
            if (!en_nx[n]) begin
                s_d.ch[n].run = 1'b0;
            end else if (trig[n]) begin
                s_d.ch[n].run = 1'b1;
            end
            // Count, wrap or zero on a qualified edge.
            ovf_set[n] = 1'b0;
            if (edge_ok[n]) begin
                if (s_q.ch[n].pend) begin
                    s_d.ch[n].cnt = CNT_ZERO;
                end else begin
                    s_d.ch[n].cnt = s_q.ch[n].cnt + CNT_ONE;
                    if (s_q.ch[n].cnt == CNT_MAX) begin
                        ovf_set[n] = 1'b1;
                        s_d.ch[n].aout = ~s_q.ch[n].aout;
                    end
                end
            end
            // A trigger waits for the next edge; a new one re-arms.
            // With a slow clock the old count stays visible until then.
            if (trig[n]) begin
                s_d.ch[n].pend = 1'b1;
            end else if (edge_ok[n]) begin
                s_d.ch[n].pend = 1'b0;
            end
            // Set wins over clear so no wrap is lost.
            // The clear stands for the read of the status word.
            s_d.ch[n].ovf = ovf_set[n]
                          | (s_q.ch[n].ovf & ~i_cmd[n].ovf_clr);
        end
    end

    // State register with synchronous reset.
    // Reset clears every field at once, so all channels start disabled.
    // Nothing here needs the reset to be held for more than one edge.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs, one set per channel.
    // Data outputs other than o_int come straight from flops; only the enables follow
    // the mode inputs directly, so a mode change turns a pin at once.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_out
            // Live count, straight from the counter flops.
            assign o_count[g]   = s_q.ch[g].cnt;
            assign o_ovf[g]     = s_q.ch[g].ovf;
            assign o_clk_sta[g] = s_q.ch[g].en;
            // Own interrupt line, masked by its enable.
            assign o_int[g]     = s_q.ch[g].ovf & i_int_en[g];
            // A drives only in waveform mode; B only if chosen.
            assign o_ioa_out[g] = s_q.ch[g].aout;
            assign o_ioa_oe[g]  = i_mode[g].wave;
            assign o_iob_out[g] = ~s_q.ch[g].aout;
            assign o_iob_oe[g]  = i_mode[g].wave & i_mode[g].b_out;
        end
    endgenerate

    // Checks run on the core clock and pause during reset.
    // Most look at the registered state; a_io_capture and a_wave_a_out see only mode inputs and pin enables.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    generate
        for (g = 0; g < NCH; g++) begin : gen_chk
            a_count_inc: assert property (
                edge_ok[g] && !s_q.ch[g].pend
                |=> o_count[g] == $past(o_count[g]) + CNT_ONE)
                else $error("count did not step");
            a_count_hold: assert property (
                !edge_ok[g] ##1 !i_reset |-> $stable(o_count[g]))
                else $error("count moved without edge");
            a_wrap_flag: assert property (
                edge_ok[g] && !s_q.ch[g].pend && o_count[g] == CNT_MAX
                |=> o_ovf[g] && o_count[g] == CNT_ZERO)
                else $error("wrap lost overflow");
            a_trig_zero: assert property (
                edge_ok[g] && s_q.ch[g].pend |=> o_count[g] == CNT_ZERO)
                else $error("trigger did not zero");
            a_trig_defer: assert property (
                trig[g] && !edge_ok[g] |=> $stable(o_count[g]))
                else $error("trigger acted early");
            a_trig_start: assert property (
                trig[g] && s_q.ch[g].en && !i_cmd[g].clk_dis
                |=> s_q.ch[g].run)
                else $error("trigger did not start");
            a_dis_stop: assert property (
                i_cmd[g].clk_dis |=> !s_q.ch[g].run && !o_clk_sta[g])
                else $error("disable ignored");
            a_int_raise: assert property (
                ovf_set[g] && i_int_en[g] ##1 i_int_en[g] |-> o_int[g])
                else $error("interrupt not raised");
            a_io_capture: assert property (
                !i_mode[g].wave |-> !o_ioa_oe[g] && !o_iob_oe[g])
                else $error("capture line driven");
            // A stopped clock never leaves the channel running.
            a_run_needs_en: assert property (
                !o_clk_sta[g] |-> !s_q.ch[g].run)
                else $error("running while disabled");
            // An enable command without a disable brings the clock back.
            a_en_restore: assert property (
                i_cmd[g].clk_en && !i_cmd[g].clk_dis |=> o_clk_sta[g])
                else $error("enable ignored");
            // A start while disabled has no effect.
            a_dis_start: assert property (
                !s_q.ch[g].en && !i_cmd[g].clk_en |=> !s_q.ch[g].run)
                else $error("start while disabled");
            // The overflow flag stays until it is cleared.
            a_ovf_sticky: assert property (
                o_ovf[g] && !i_cmd[g].ovf_clr |=> o_ovf[g])
                else $error("overflow flag dropped");
            // A clear without a new wrap empties the flag.
            a_ovf_clear: assert property (
                i_cmd[g].ovf_clr && !ovf_set[g] |=> !o_ovf[g])
                else $error("overflow clear ignored");
            // A masked channel keeps its interrupt line low.
            a_int_mask: assert property (
                !i_int_en[g] |-> !o_int[g])
                else $error("masked interrupt raised");
            // A low burst line lets no edge through.
            a_burst_block: assert property (
                i_mode[g].burst != BU_NONE && !gate[g] |-> !edge_ok[g])
                else $error("burst gate leaked");
            // Waveform mode always drives line A.
            a_wave_a_out: assert property (
                i_mode[g].wave |-> o_ioa_oe[g])
                else $error("line A not driven");
            // A counting edge with no new trigger ends the pending zero.
            a_pend_clear: assert property (
                edge_ok[g] && !trig[g] |=> !s_q.ch[g].pend)
                else $error("pending zero kept");
            c_wrap: cover property (ovf_set[g]);
            c_trig: cover property (edge_ok[g] && s_q.ch[g].pend);
            c_burst: cover property (edge_ok[g] && i_mode[g].burst != BU_NONE);
            c_invert: cover property (edge_ok[g] && i_mode[g].clk_inv);
            c_restart: cover property (i_cmd[g].clk_en && trig[g]);
        end
    endgenerate

    a_block_start: assert property (
        i_block_sync && (&s_q.ch[0].en) && s_q.ch[1].en && s_q.ch[2].en
        && !i_cmd[0].clk_dis && !i_cmd[1].clk_dis && !i_cmd[2].clk_dis
        |=> s_q.ch[0].run && s_q.ch[1].run && s_q.ch[2].run)
        else $error("block start missed a channel");

    // Stage two of every synchroniser copies stage one a cycle late.
    a_sync_pipe: assert property (
        s_q.pin_s2 == $past(s_q.pin_s1) && s_q.ioa_s2 == $past(s_q.ioa_s1))
        else $error("synchroniser stage skipped");

endmodule

// ---- verif/tcc_src.sv ----
// Model of the outside clock source that drives the timer pins.
`timescale 1ns/1ns
module tcc_src (
    input  wire logic i_core_clk,
    input  wire logic i_run,
    output logic [2:0] o_pin,
    output int         o_rises
);
    int ph = 0;
    initial o_pin = 3'h0;
    initial o_rises = 0;
    // Six core cycles a period keeps the rate well below master/2.5.
    // A high level always finishes its half period, so no level is too short.
    always @(posedge i_core_clk) begin
        if (!i_run && o_pin == 3'h0) begin
            ph <= 0; // Idle: stands still low between runs.
        end else if (ph == 2) begin
            ph <= 0;
            o_pin <= ~o_pin;
            if (o_pin == 3'h0) begin
                o_rises <= o_rises + 1;
            end
        end else begin
            ph <= ph + 1;
        end
    end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the three-channel timer core.
`timescale 1ns/1ns
module tb;
    import tcc_pkg::*;
    logic                   i_core_clk, i_reset, i_block_sync, src_run;
    logic [NTAP-1:0]        i_tap;
    logic [2:0][1:0]        i_xc_route;
    tcc_mode_t [NCH-1:0]    i_mode;
    tcc_cmd_t  [NCH-1:0]    i_cmd;
    logic [NCH-1:0]         i_int_en, o_ovf, o_clk_sta, o_int, o_ioa_out, o_ioa_oe, o_iob_out, o_iob_oe;
    logic [NCH-1:0][CW-1:0] o_count;
    logic [2:0]             pin;
    logic [15:0]            e;
    int                     rises, r0, n_mismatch, checks;

    tcc_core uut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_tap(i_tap), .i_ext_pin(pin),
        .i_xc_route(i_xc_route), .i_mode(i_mode), .i_cmd(i_cmd), .i_block_sync(i_block_sync),
        .i_int_en(i_int_en), .i_ioa_in(pin), .i_iob_in(pin), .o_count(o_count), .o_ovf(o_ovf),
        .o_clk_sta(o_clk_sta), .o_int(o_int), .o_ioa_out(o_ioa_out), .o_ioa_oe(o_ioa_oe),
        .o_iob_out(o_iob_out), .o_iob_oe(o_iob_oe));
    tcc_src src (.i_core_clk(i_core_clk), .i_run(src_run), .o_pin(pin), .o_rises(rises));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    // One-cycle command pulse; the idle cycle after it keeps pulses apart.
    task automatic cmd(input int c, input tcc_cmd_t v);
        i_cmd[c] = v;
        cyc(1);
        i_cmd[c] = '0;
        cyc(1);
    endtask
    // Slow tap pulses, two cycles per level, then settle.
    task automatic pulses(input logic [4:0] m, input int n);
        repeat (n) begin
            i_tap = m;
            cyc(2);
            i_tap = 5'h00;
            cyc(2);
        end
        cyc(3);
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end
    // Watchdog: the tests need about 850 cycles.
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        i_reset = 1'b1;
        i_tap = 5'h00;
        i_xc_route = '0;
        i_mode = '0;
        i_cmd = '0;
        i_block_sync = 1'b0;
        i_int_en = 3'h7;
        src_run = 1'b0;
        n_mismatch = 0;
        checks = 0;
        cyc(12);
        i_reset = 1'b0;
        chk(o_count[0], CNT_ZERO);
        // Trigger while disabled must not start counting.
        cmd(0, 4'h8);
        pulses(5'h01, 3);
        chk(o_count[0], CNT_ZERO);
        cmd(0, 4'h4);
        chk(16'(o_clk_sta), 16'h0001);
        // Every tap code; the first edge after a trigger zeroes the count.
        for (int k = 0; k < NTAP; k++) begin
            i_mode[0].clk_sel = 3'(k);
            cmd(0, 4'h8);
            chk(o_count[0], (k == 0) ? CNT_ZERO : 16'h0003);
            pulses(5'(1 << k), 4);
            chk(o_count[0], 16'h0003);
        end
        // Inverted clock counts tap falls only.
        i_mode[0].clk_sel = CS_TAP1;
        i_mode[0].clk_inv = 1'b1;
        cmd(0, 4'h8);
        pulses(5'h01, 2);
        i_tap = 5'h01;
        cyc(5);
        chk(o_count[0], 16'h0001);
        i_tap = 5'h00;
        i_mode[0].clk_inv = 1'b0;
        // Each line with each routing; pins and A inputs share the source.
        for (int n = 0; n < 3; n++) begin
            for (int r = 0; r < 4; r++) begin
                i_xc_route[n] = 2'(r);
                i_mode[0].clk_sel = CS_XC0 + 3'(n);
                cmd(0, 4'h8);
                r0 = rises;
                src_run = 1'b1;
                cyc(40);
                src_run = 1'b0;
                cyc(10);
                if (r < 3) begin
                    e = 16'(rises - r0 - 1);
                end
                chk(o_count[0], e);
            end
        end
        // Burst on a line held low blocks counting, zeroing included.
        i_mode[0].clk_sel = CS_TAP1;
        i_mode[0].burst = BU_XC0;
        cmd(0, 4'h8);
        pulses(5'h01, 3);
        chk(o_count[0], e);
        i_mode[0].burst = BU_NONE;
        pulses(5'h01, 3);
        chk(o_count[0], 16'h0002);
        // One sync pulse starts all three channels together.
        cmd(1, 4'h4);
        cmd(2, 4'h4);
        i_block_sync = 1'b1;
        cyc(1);
        i_block_sync = 1'b0;
        cyc(1);
        pulses(5'h01, 4);
        for (int c = 0; c < NCH; c++) begin
            chk(o_count[c], 16'h0003);
        end
        // Disabled clock freezes the count.
        cmd(0, 4'h2);
        pulses(5'h01, 2);
        chk(o_count[0], 16'h0003);
        chk(16'(o_clk_sta), 16'h0006);
        chk(16'(o_int), 16'h0000);
        // Line direction follows the mode bits.
        for (int w = 0; w < 4; w++) begin
            i_mode[1].wave = w[0];
            i_mode[1].b_out = w[1];
            cyc(1);
            chk(16'({o_iob_oe[1], o_ioa_oe[1]}), 16'({w[1] & w[0], w[0]}));
        end
        chk(16'(o_ovf), 16'h0000);
        chk(16'({o_iob_out, o_ioa_out}), 16'h0038);
        stop_test();
    end
endmodule
